// ===== hdl/cif_pkg.sv
// Constants and types shared by the 3x3 image convolution filter
// Summary of operation
// - Each output is the sum of nine weight times neighbourhood pixel products.
// - Three RAM line stores hold the rows that form each neighbourhood.
// - Each store holds one row; the newest row rotates through all three.
// - Control logic makes line-store addresses and enables, interleaving rows.
// - Signed 9-bit weights go straight to the multipliers, not buffered.
// - A selection stage catches taps beyond the image edge before multiplying.
// - Out-of-image taps read as zero, as if the image were zero-padded.
// - Nine multiplies run in parallel and an adder tree sums them.
// - Symmetric mode pre-adds pixels sharing one weight before multiplying.
// - The kernel visits every input position, edges included.
// - Output is 8x8, emitted in raster order.
package cif_pkg;

  // ==========================================================
  // Image and data geometry
  localparam int IMG_W = 8;
  localparam int IMG_H = 8;
  localparam int PIX_W = 8;
  localparam int WT_W = 9;
  localparam int OUT_W = 21;
  localparam int NTAP = 9;
  localparam int NSTORE = 3;
  localparam int CNT_W = 4;
  localparam int COL_AW = 3;

  // ==========================================================
  // Scan limits: one extra phantom column and row flush the window
  localparam logic [CNT_W-1:0] COL_LAST = 4'h8;
  localparam logic [CNT_W-1:0] ROW_LAST = 4'h8;
  localparam logic [CNT_W-1:0] COL_REAL = 4'h8;
  localparam logic [CNT_W-1:0] ROW_REAL = 4'h8;

  // ==========================================================
  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [PIX_W-1:0] PIX_ZERO = 8'h00;

  // ==========================================================
  // Tap positions in the 3x3 window, raster order
  localparam int TAP_CENTRE = 4;
  localparam int WT_CENTRE = 4;
  localparam int WT_EDGE = 1;
  localparam int WT_CORNER = 0;

  typedef logic [PIX_W-1:0] cif_pix_t;
  typedef logic signed [WT_W-1:0] cif_wt_t;
  typedef logic signed [OUT_W-1:0] cif_acc_t;

endpackage

// ===== hdl/cif_tap_if.sv
// Window taps, weights and mode passed from the line-store stage to the multiply-add
`timescale 1ns/1ps
`default_nettype none
interface cif_tap_if;
  import cif_pkg::*;
  cif_pix_t tap [NTAP];
  cif_wt_t wt [NTAP];
  logic sym;
  logic vld;
  modport src (output tap, output wt, output sym, output vld);
  modport mac (input tap, input wt, input sym, input vld);
endinterface
`default_nettype wire

// ===== hdl/cif_mac.sv
// Parallel multiply and adder tree, full and symmetric kernels
`timescale 1ns/1ps
`default_nettype none
module cif_mac
  import cif_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Window taps
  cif_tap_if.mac m,
  // Result
  output logic out_valid,
  output cif_acc_t out_data
);

  function automatic cif_acc_t ext(input cif_pix_t p);
    ext = $signed({{(OUT_W-PIX_W){1'b0}}, p});
  endfunction

  // ==========================================================
  // Full kernel: nine products at once
  cif_acc_t prod [NTAP];
  cif_acc_t lvl1 [5];
  cif_acc_t lvl2 [3];
  cif_acc_t full_sum;

  genvar i;
  generate
    for (i = 0; i < NTAP; i++) begin : g_mul
      assign prod[i] = ext(m.tap[i]) * OUT_W'(m.wt[i]);
    end
    for (i = 0; i < 4; i++) begin : g_l1
      assign lvl1[i] = prod[2*i] + prod[2*i+1];
    end
  endgenerate
  assign lvl1[4] = prod[8];
  assign lvl2[0] = lvl1[0] + lvl1[1];
  assign lvl2[1] = lvl1[2] + lvl1[3];
  assign lvl2[2] = lvl1[4];
  assign full_sum = lvl2[0] + lvl2[1] + lvl2[2];

  // ==========================================================
  // Symmetric kernel: pixels sharing a weight are added first
  cif_acc_t edge_sum;
  cif_acc_t corner_sum;
  cif_acc_t sym_sum;

  assign edge_sum = ext(m.tap[1]) + ext(m.tap[3]) + ext(m.tap[5]) + ext(m.tap[7]);
  assign corner_sum = ext(m.tap[0]) + ext(m.tap[2]) + ext(m.tap[6]) + ext(m.tap[8]);
  assign sym_sum = ext(m.tap[TAP_CENTRE]) * OUT_W'(m.wt[WT_CENTRE])
                 + edge_sum * OUT_W'(m.wt[WT_EDGE])
                 + corner_sum * OUT_W'(m.wt[WT_CORNER]);

  // ==========================================================
  // Output register
  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= m.vld;
      if (m.vld) begin
        out_data <= m.sym ? sym_sum : full_sum;
      end
    end
  end

endmodule
`default_nettype wire

// ===== hdl/cif_filter.sv
// Top of the 3x3 image convolution filter: line stores, control, edge select
`timescale 1ns/1ps
`default_nettype none
module cif_filter
  import cif_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pixel input stream
  input wire logic pix_valid,
  input wire cif_pix_t pix_data,
  output logic pix_ready,
  // Kernel
  input wire cif_wt_t weight [NTAP],
  input wire logic sym_en,
  // Pixel output stream
  output logic out_valid,
  output cif_acc_t out_data
);

  // Store holding the row n rows above the one being written
  function automatic logic [1:0] sel_back(input logic [1:0] sel, input logic [1:0] n);
    logic [2:0] s;
    s = {1'b0, sel} + 3'(NSTORE) - {1'b0, n};
    if (s >= 3'(NSTORE)) begin
      s = s - 3'(NSTORE);
    end
    sel_back = s[1:0];
  endfunction

  // ==========================================================
  // Scan counters and store pointer
  // The scan runs over 9x9 positions; the ninth column and row are phantom
  // steps that need no input and flush the last outputs of each row and frame.
  logic [CNT_W-1:0] row_q;
  logic [CNT_W-1:0] col_q;
  logic [1:0] wr_sel_q;
  logic step;
  logic col_end;
  logic row_end;
  logic real_pos;

  assign col_end = (col_q == COL_LAST);
  assign row_end = (row_q == ROW_LAST);
  assign real_pos = (row_q < ROW_REAL) && (col_q < COL_REAL);
  assign pix_ready = real_pos;
  assign step = real_pos ? pix_valid : 1'b1;

  always_ff @(posedge clk) begin
    if (srst) begin
      row_q <= CNT_RST;
      col_q <= CNT_RST;
      wr_sel_q <= SEL_RST;
    end else if (step) begin
      if (col_end) begin
        col_q <= CNT_RST;
        if (row_end) begin
          row_q <= CNT_RST;
          wr_sel_q <= SEL_RST;
        end else begin
          row_q <= row_q + 4'h1;
          wr_sel_q <= sel_back(wr_sel_q, 2'h2);
        end
      end else begin
        col_q <= col_q + 4'h1;
      end
    end
  end

  // ==========================================================
  // Line stores, one image row each
  cif_pix_t store_q [NSTORE][IMG_W];
  logic [COL_AW-1:0] col_addr;
  logic [1:0] sel_m1;
  logic [1:0] sel_m2;
  logic wr_en;

  assign col_addr = col_q[COL_AW-1:0];
  assign sel_m1 = sel_back(wr_sel_q, 2'h1);
  assign sel_m2 = sel_back(wr_sel_q, 2'h2);
  assign wr_en = step && real_pos;

  always_ff @(posedge clk) begin
    if (wr_en) begin
      store_q[wr_sel_q][col_addr] <= pix_data;
    end
  end

  // ==========================================================
  // Edge select: new window column, zeros outside the image
  cif_pix_t new_col [3];
  logic top_in;
  logic mid_in;
  logic bot_in;

  assign top_in = !col_end && (row_q >= 4'h2);
  assign mid_in = !col_end && (row_q >= 4'h1);
  assign bot_in = !col_end && !row_end;
  assign new_col[0] = top_in ? store_q[sel_m2][col_addr] : PIX_ZERO;
  assign new_col[1] = mid_in ? store_q[sel_m1][col_addr] : PIX_ZERO;
  assign new_col[2] = bot_in ? pix_data : PIX_ZERO;

  // ==========================================================
  // 3x3 window; the phantom column leaves zeros for the next left edge
  cif_pix_t win_q [3][3];
  logic win_valid_q;

  genvar r;
  generate
    for (r = 0; r < 3; r++) begin : g_win
      always_ff @(posedge clk) begin
        if (srst) begin
          win_q[r][0] <= PIX_ZERO;
          win_q[r][1] <= PIX_ZERO;
          win_q[r][2] <= PIX_ZERO;
        end else if (step) begin
          win_q[r][0] <= win_q[r][1];
          win_q[r][1] <= win_q[r][2];
          win_q[r][2] <= new_col[r];
        end
      end
    end
  endgenerate

  // Position (row-1, col-1) is complete once (row, col) is stepped
  always_ff @(posedge clk) begin
    if (srst) begin
      win_valid_q <= 1'b0;
    end else begin
      win_valid_q <= step && (row_q != CNT_RST) && (col_q != CNT_RST);
    end
  end

  // ==========================================================
  // Multiply-add stage
  cif_tap_if taps ();

  genvar t;
  generate
    for (t = 0; t < NTAP; t++) begin : g_tap
      assign taps.tap[t] = win_q[t/3][t%3];
      assign taps.wt[t] = weight[t];
    end
  endgenerate
  assign taps.sym = sym_en;
  assign taps.vld = win_valid_q;

  cif_mac u_mac (
    .clk(clk),
    .srst(srst),
    .m(taps.mac),
    .out_valid(out_valid),
    .out_data(out_data)
  );

endmodule
`default_nettype wire

// ===== test/cif_checker.sv
// Port assertions for the image filter
`timescale 1ns/1ps
`default_nettype none
module cif_checker
  import cif_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Streams
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic out_valid,
  input wire cif_acc_t out_data
);
  // ==========
  // Transfer counts
  logic [15:0] in_q;
  logic [15:0] out_q;
  wire logic tk = pix_valid && pix_ready;
  wire logic row_end = tk && in_q[2:0] == 3'h7 && in_q[5:3] != 3'h7;
  wire logic frm_end = tk && in_q[5:0] == 6'h3F;
  always_ff @(posedge clk) begin
    in_q <= srst ? 16'h0 : in_q + 16'(tk);
    out_q <= srst ? 16'h0 : out_q + 16'(out_valid);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_RST: assert property ($fell(srst) |-> pix_ready && !out_valid && !out_data)
    else $error("reset state");
  AST_ROW_GAP: assert property (row_end |=> !pix_ready ##1 pix_ready)
    else $error("row gap");
  AST_FRM_GAP: assert property (frm_end |=> !pix_ready [*8] ##1 !pix_ready [*2] ##1 pix_ready)
    else $error("frame gap");
  AST_FRM_DONE: assert property (frm_end |-> ##[2:16] out_q == in_q)
    else $error("frame outputs");
  AST_AHEAD: assert property (out_q <= in_q)
    else $error("output ahead");
  AST_FIRST: assert property (out_valid && !out_q[5:0] |-> in_q[5:0] > 6'h9)
    else $error("early output");
  AST_HOLD: assert property (!out_valid && !$past(srst) |-> $stable(out_data))
    else $error("data moved");
  AST_FALL: assert property ($fell(pix_ready) |-> $past(row_end) || $past(frm_end))
    else $error("ready drop");
  cover property (frm_end);
  cover property (row_end ##1 pix_valid);
  cover property (out_valid [*2]);
endmodule
bind cif_filter cif_checker chk_u (.clk, .srst, .pix_valid, .pix_ready, .out_valid, .out_data);
`default_nettype wire

// ===== test/cif_src_model.sv
// Upstream pixel source: one frame in raster order, optional stalls
`timescale 1ns/1ps
`default_nettype none
module cif_src_model
  import cif_pkg::*;
(
  // Control
  input wire logic clk,
  input wire logic go,
  input wire logic gap,
  input wire cif_pix_t img [IMG_W*IMG_H],
  // Pixel stream
  output logic pix_valid,
  output cif_pix_t pix_data,
  input wire logic pix_ready
);
  // ==========
  // An offer is held until the device takes it
  int idx = 64;
  logic took = 1'b0;
  logic start = 1'b0;
  logic hold_off = 1'b0;
  initial begin
    pix_valid = 1'b0;
    pix_data = 8'hA5;
  end
  // Bench controls change on the falling edge; sample them on the rising one to avoid a race
  always @(posedge clk) begin
    took <= pix_valid && pix_ready;
    start <= go;
    hold_off <= gap;
  end
  always @(negedge clk) begin
    if (start) idx = 0;
    else if (took) idx = idx + 1;
    if (idx < 64 && (!hold_off || (pix_valid && !took))) begin
      pix_valid = 1'b1;
      pix_data = img[idx];
    end else begin
      pix_valid = 1'b0;
      pix_data = ~pix_data; // Stale data must never look valid
    end
  end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Bench: frames through the filter against a zero-padded convolution
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cif_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, go = 1'b0, gap = 1'b0, stall = 1'b0, sym_en = 1'b0;
  logic pix_valid, pix_ready, out_valid;
  logic [31:0] lfsr = 32'h1449;
  cif_pix_t pix_data, img [IMG_W*IMG_H];
  cif_wt_t weight [NTAP], w;
  cif_acc_t out_data, s, exp_q [$];
  int miscompares = 0, cmp_count = 0, rr, cc;
  // ==========
  cif_src_model src_u (.clk, .go, .gap, .img, .pix_valid, .pix_data, .pix_ready);
  cif_filter dut_u (.clk, .srst, .pix_valid, .pix_data, .pix_ready, .weight, .sym_en,
    .out_valid, .out_data);
  initial forever #50 clk = ~clk;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  always @(negedge clk) begin
    lfsr = nxt(lfsr);
    gap = stall & lfsr[2] & lfsr[5];
    if (!srst && out_valid === 1'b1) begin
      cmp_count++;
      if (exp_q.size() == 0 || out_data !== exp_q[0]) begin
        miscompares++;
        $display("unexpected out_data expected %0d seen %0d", exp_q[0], out_data);
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic run_frame(input logic sm, input int kind, input logic st);
    @(negedge clk);
    sym_en = sm;
    stall = st;
    for (int i = 0; i < 73; i++) begin
      lfsr = nxt(lfsr);
      if (i < 9) weight[i] = kind == 1 ? 9'h100 : kind == 2 ? 9'h0FF : lfsr[8:0];
      else img[i-9] = kind ? 8'hFF : lfsr[7:0];
    end
    for (int p = 0; p < 64; p++) begin
      s = 21'h0;
      for (int k = 0; k < 9; k++) begin
        rr = p / 8 + k / 3 - 1;
        cc = p % 8 + k % 3 - 1;
        w = !sm || k == 4 ? weight[k] : weight[k % 2];
        if (rr >= 0 && rr < 8 && cc >= 0 && cc < 8)
          s += w * $signed({1'b0, img[rr*8+cc]});
      end
      exp_q.push_back(s);
    end
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (int t = 0; t < 400 && exp_q.size() > 0; t++) @(negedge clk);
    if (exp_q.size() > 0) begin
      miscompares++;
      wrap_up();
    end
    $display("frame sym %0b kind %0d stall %0b done", sm, kind, st);
  endtask
  initial begin
    foreach (weight[k]) weight[k] = 9'h0;
    repeat (8) @(negedge clk);
    srst = 1'b0;
    run_frame(1'b0, 0, 1'b0);
    run_frame(1'b0, 0, 1'b1);
    run_frame(1'b1, 0, 1'b1);
    run_frame(1'b0, 1, 1'b1);
    run_frame(1'b1, 2, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
